// ---- inc/drt_pkg.sv ----
// Constants, types and the region decoder for the debug component list table.
// Assumes a 12-bit byte offset within one 4KB block and 32-bit read data.
//
// Contract
// - Size and continuation word at 0xFD0.
// - Bits 7:4 block count, 3:0 continuation.
// - Legacy may reuse the 0xFD0 word.
// - Words 0xFD4 to 0xFDC read zero.
// - Legacy may reuse words 0xFD4 to 0xFDC.
// - Legacy implements four words, ASCII designer code.
// - Legacy fourth word low byte is build configuration.
// - Table occupies exactly one 4KB block.
// - Writes never change any contents.
// - Storage format is 8-bit or 32-bit.
// - 8-bit format stores entries low byte first.
// - Fixed map: entries, type, identification words.
// - Only reserved area size depends on format; here the reserved area is 0xF00 to 0xFCB in both formats.
// - Offsets 0xF00 to 0xFCB read zero.
// - Last possible entry sits at 0xEFC.
// - Byte locations return zero in bits 31:8.
// - Table reads like plain memory by address.
// - Entry holds offset, format flag, present flag.
// - Unused area after entries reads zero.
// - Identity flag set when standard code used.

package drt_pkg;

    // Byte offsets of the regions and registers within the 4KB block.
    localparam logic [11:0] OFS_ENTRY_FIRST = 12'h000;
    localparam logic [11:0] OFS_ENTRY_LAST = 12'hEFC;
    localparam logic [11:0] OFS_RESERVED = 12'hF00;
    localparam logic [11:0] OFS_MEMORY_TYPE = 12'hFCC;
    localparam logic [11:0] OFS_SIZE_CONT = 12'hFD0;
    localparam logic [11:0] OFS_RESERVED_FIFTH = 12'hFD4;
    localparam logic [11:0] OFS_RESERVED_SIXTH = 12'hFD8;
    localparam logic [11:0] OFS_RESERVED_SEVENTH = 12'hFDC;
    localparam logic [11:0] OFS_PART_LOW = 12'hFE0;
    localparam logic [11:0] OFS_PART_HIGH = 12'hFE4;
    localparam logic [11:0] OFS_REVISION = 12'hFE8;
    localparam logic [11:0] OFS_BUILD_CONFIG = 12'hFEC;
    localparam logic [11:0] OFS_COMPONENT_ID = 12'hFF0;

    // Field positions inside identification words and table entries.
    localparam int BLOCK_COUNT_LSB = 4;
    localparam int CONTINUATION_LSB = 0;
    localparam int IDENT_USED_BIT = 3;
    localparam int ENTRY_OFFSET_LSB = 12;
    localparam int ENTRY_FORMAT_BIT = 1;
    localparam int ENTRY_PRESENT_BIT = 0;

    // Capacity of the entry area in each storage format.
    localparam int MAX_ENTRIES_32 = 960;
    localparam int MAX_ENTRIES_8 = 240;

    // Read answer timing and values after reset.
    localparam int READ_LATENCY = 2;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef logic [31:0] drt_word_t;

    // Regions that a word offset can fall into.
    typedef enum logic [1:0] {
        DRT_RG_ENTRY,
        DRT_RG_ZERO,
        DRT_RG_IDENT
    } drt_region_e;

    // Classifies a byte offset; the entry area ends at the reserved start.
    function automatic drt_region_e drt_region(input logic [11:0] ofs);
        if (ofs >= OFS_MEMORY_TYPE) begin
            return DRT_RG_IDENT;
        end else if (ofs >= OFS_RESERVED) begin
            return DRT_RG_ZERO;
        end else begin
            return DRT_RG_ENTRY;
        end
    endfunction

endpackage

// ---- inc/drt_lookup_if.sv ----
// Lookup carrier between the table top and its two content stores.
// Assumes the store answers one clock after the index is presented.
`timescale 1ns/1ns
`default_nettype none

interface drt_lookup_if;
    logic [9:0] index; // Word or entry index presented by the top.
    logic [31:0] data; // Registered word returned by the store.

    modport requester (output index, input data);
    modport provider (input index, output data);
endinterface

`default_nettype wire

// ---- hw/drt_entry_rom.sv ----
// Constant store for the component entries of the table.
// Assumes the index is stable on the clock edge; data comes out of a register.
`timescale 1ns/1ns
`default_nettype none

module drt_entry_rom #(
    parameter int DEPTH = 2,
    parameter logic [DEPTH*32-1:0] CONTENTS = '0
) (
    input wire logic clock,
    input wire logic rst,
    drt_lookup_if.provider lk
);
    import drt_pkg::*;

    logic [31:0] data_q; // Registered read word.
    logic [31:0] data_d; // Word selected this cycle.

    // Indices past the last entry read as the blank or unused area.
    assign data_d = (32'(lk.index) < DEPTH) ? CONTENTS[lk.index*32 +: 32] : WORD_ZERO;
    assign lk.data = data_q;

    // The store is read-only, so the only state is the output register.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            data_q <= WORD_ZERO;
        end else begin
            data_q <= data_d;
        end
    end
endmodule

`default_nettype wire

// ---- hw/drt_ident_regs.sv ----
// Memory type and identification words at the top of the 4KB block.
// Assumes the index is byte offset bits 5:2, so 3 is 0xFCC and 15 is 0xFFC.
`timescale 1ns/1ns
`default_nettype none

module drt_ident_regs #(
    parameter bit LEGACY = 1'b0,
    parameter logic [31:0] MEMORY_TYPE = 32'h0000_0000,
    parameter logic [3:0] BLOCK_COUNT_LOG2 = 4'h0,
    parameter logic [3:0] CONTINUATION = 4'h0,
    parameter logic [11:0] PART_NUMBER = 12'h000,
    parameter logic [6:0] DESIGNER_CODE = 7'h00,
    parameter logic [3:0] REVISION = 4'h0,
    parameter logic [3:0] REV_AND = 4'h0,
    parameter logic [3:0] CUSTOMER_MOD = 4'h0,
    parameter logic [7:0] BUILD_CONFIG = 8'h00,
    parameter logic [127:0] LEGACY_WORDS = '0,
    parameter logic [31:0] COMPONENT_ID = 32'h0000_0000
) (
    input wire logic clock,
    input wire logic rst,
    drt_lookup_if.provider lk
);
    import drt_pkg::*;

    logic [31:0] data_q; // Registered identification word.
    logic [31:0] data_d; // Word chosen by the index.
    logic [3:0] idx; // Low index bits name one of sixteen words.
    logic [31:0] size_word; // Standard 0xFD0 layout.

    assign idx = lk.index[3:0];
    assign size_word = {24'h00_0000, BLOCK_COUNT_LOG2, CONTINUATION};

    // Selects the constant word; any index not listed reads zero.
    always_comb begin
        data_d = WORD_ZERO;
        case (idx)
            4'h3: data_d = MEMORY_TYPE;
            4'h4: data_d = LEGACY ? LEGACY_WORDS[31:0] : size_word;
            4'h5: data_d = LEGACY ? LEGACY_WORDS[63:32] : WORD_ZERO;
            4'h6: data_d = LEGACY ? LEGACY_WORDS[95:64] : WORD_ZERO;
            4'h7: data_d = LEGACY ? LEGACY_WORDS[127:96] : WORD_ZERO;
            4'h8: data_d = {24'h00_0000, PART_NUMBER[7:0]};
            4'h9: data_d = {24'h00_0000, DESIGNER_CODE[3:0], PART_NUMBER[11:8]};
            4'hA: data_d = {24'h00_0000, REVISION, ~LEGACY, DESIGNER_CODE[6:4]};
            4'hB: data_d = LEGACY ? {24'h00_0000, BUILD_CONFIG}
                                  : {24'h00_0000, REV_AND, CUSTOMER_MOD};
            4'hC: data_d = {24'h00_0000, COMPONENT_ID[7:0]};
            4'hD: data_d = {24'h00_0000, COMPONENT_ID[15:8]};
            4'hE: data_d = {24'h00_0000, COMPONENT_ID[23:16]};
            4'hF: data_d = {24'h00_0000, COMPONENT_ID[31:24]};
            default: data_d = WORD_ZERO;
        endcase
    end

    assign lk.data = data_q;

    // Output register; contents never change, so reads have no side effects.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            data_q <= WORD_ZERO;
        end else begin
            data_q <= data_d;
        end
    end
endmodule

`default_nettype wire

// ---- hw/drt_rom_table.sv ----
// Top of the read-only debug component list table and identification space.
// Assumes a memory access port drives a simple select, write, address
// handshake on the debug bus, one request at most per clock.
`timescale 1ns/1ns
`default_nettype none

module drt_rom_table #(
    // Storage format: 1 for one word per entry, 0 for one byte per word.
    parameter bit FORMAT_32 = 1'b1,
    // Number of stored entries, the blank terminator not counted.
    parameter int NUM_ENTRIES = 2,
    // Entry words, entry 0 in the lowest 32 bits.
    parameter logic [NUM_ENTRIES*32-1:0] ENTRIES = {32'h0000_2003, 32'hFFF0_F003},
    // Legacy identification layout with an ASCII designer code.
    parameter bit LEGACY = 1'b0,
    parameter logic [31:0] MEMORY_TYPE = 32'h0000_0000,
    parameter logic [3:0] BLOCK_COUNT_LOG2 = 4'h0,
    // Designer codes below are arbitrary neutral values.
    parameter logic [3:0] CONTINUATION = 4'h0,
    parameter logic [6:0] DESIGNER_CODE = 7'h00,
    parameter logic [11:0] PART_NUMBER = 12'h000,
    parameter logic [3:0] REVISION = 4'h0,
    parameter logic [3:0] REV_AND = 4'h0,
    parameter logic [3:0] CUSTOMER_MOD = 4'h0,
    parameter logic [7:0] BUILD_CONFIG = 8'h00,
    parameter logic [127:0] LEGACY_WORDS = '0,
    parameter logic [31:0] COMPONENT_ID = 32'h0000_0000
) (
    input wire logic clock,
    input wire logic rst,
    // Request strobe from the memory access port, one cycle per access.
    input wire logic bus_sel,
    // High for a write, which is accepted and discarded.
    input wire logic bus_write,
    // Byte offset within the 4KB block; bits 1:0 are ignored.
    input wire logic [11:0] bus_addr,
    // Write data, never stored.
    input wire logic [31:0] bus_wdata,
    // Read data, valid while bus_ready is high.
    output logic [31:0] bus_rdata,
    // One-cycle answer, two clocks after the request.
    output logic bus_ready
);
    import drt_pkg::*;

    // Capacity of the entry area for the chosen format.
    localparam int MAX_ENTRIES = FORMAT_32 ? MAX_ENTRIES_32 : MAX_ENTRIES_8;

    // Refuse a table that cannot fit below the reserved area.
    if (NUM_ENTRIES < 1 || NUM_ENTRIES > MAX_ENTRIES) begin : g_bad_count
        $error("entry count does not fit the entry area");
    end

    // Every entry must carry the format flag that matches the storage format.
    for (genvar i = 0; i < NUM_ENTRIES; i++) begin : g_entry_check
        if (ENTRIES[i*32+ENTRY_FORMAT_BIT] != FORMAT_32) begin : g_bad_format
            $error("entry format flag differs from storage format");
        end
        if (ENTRIES[i*32+ENTRY_OFFSET_LSB +: 20] == 20'h0_0000) begin : g_bad_offset
            $error("entry offset points back at the table");
        end
    end

    // Carriers to the two constant stores.
    drt_lookup_if entry_lk ();
    drt_lookup_if ident_lk ();

    // ------------------------------------------------------------------
    // Address decode, request cycle.
    // ------------------------------------------------------------------

    logic [9:0] word_index; // Word offset of the request.
    drt_region_e region; // Region the request falls into.
    logic [9:0] entry_index; // Entry number addressed in the entry area.
    logic [1:0] byte_lane; // Byte of the entry in the 8-bit format.
    logic read_req; // A read was presented this cycle.
    logic write_req; // A write was presented this cycle.

    // Only the 4KB block is decoded; bits above are the bus's business.
    assign word_index = bus_addr[11:2];
    assign region = drt_region(bus_addr);

    // In the 8-bit format four words make one entry, low byte first, so
    // the entry number drops two bits and those bits pick the byte.
    assign entry_index = FORMAT_32 ? word_index : {2'b00, word_index[9:2]};
    assign byte_lane = FORMAT_32 ? 2'b00 : word_index[1:0];

    assign read_req = bus_sel && !bus_write;
    assign write_req = bus_sel && bus_write;

    // Both stores see the index every cycle; they have no read side effects,
    // so looking up on idle cycles costs nothing but toggling.
    assign entry_lk.index = entry_index;
    assign ident_lk.index = word_index;

    // The entry store answers zero past the last entry, which covers the
    // blank terminator and the unused area up to the reserved start.
    drt_entry_rom #(
        .DEPTH(NUM_ENTRIES),
        .CONTENTS(ENTRIES)
    ) u_entries (
        .clock(clock),
        .rst(rst),
        .lk(entry_lk.provider)
    );

    // Memory type, identification and component words share one store.
    drt_ident_regs #(
        .LEGACY(LEGACY),
        .MEMORY_TYPE(MEMORY_TYPE),
        .BLOCK_COUNT_LOG2(BLOCK_COUNT_LOG2),
        .CONTINUATION(CONTINUATION),
        .PART_NUMBER(PART_NUMBER),
        .DESIGNER_CODE(DESIGNER_CODE),
        .REVISION(REVISION),
        .REV_AND(REV_AND),
        .CUSTOMER_MOD(CUSTOMER_MOD),
        .BUILD_CONFIG(BUILD_CONFIG),
        .LEGACY_WORDS(LEGACY_WORDS),
        .COMPONENT_ID(COMPONENT_ID)
    ) u_ident (
        .clock(clock),
        .rst(rst),
        .lk(ident_lk.provider)
    );

    // ------------------------------------------------------------------
    // First pipeline stage: remember what the store outputs will mean.
    // ------------------------------------------------------------------

    logic stage_read_q; // A read is in flight to the stores.
    logic stage_write_q; // A write is in flight, to be acknowledged only.
    drt_region_e stage_region_q; // Region of the access in flight.
    logic [1:0] stage_lane_q; // Byte lane of the access in flight.

    // Captures the request so that it lines up with the registered stores.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stage_read_q <= 1'b0;
            stage_write_q <= 1'b0;
            stage_region_q <= DRT_RG_ZERO;
            stage_lane_q <= 2'b00;
        end else begin
            stage_read_q <= read_req;
            stage_write_q <= write_req;
            stage_region_q <= region;
            stage_lane_q <= byte_lane;
        end
    end

    // ------------------------------------------------------------------
    // Answer selection, second cycle.
    // ------------------------------------------------------------------

    logic [31:0] entry_word; // Stored entry addressed by the request.
    logic [7:0] entry_byte; // Selected byte of that entry.
    logic [31:0] entry_answer; // Entry area answer in the active format.
    logic [31:0] read_answer; // Answer for the region in flight.
    logic [31:0] rdata_d; // Next read data.
    logic [31:0] rdata_q; // Read data register.
    logic ready_d; // Next answer strobe.
    logic ready_q; // Answer strobe register.

    assign entry_word = entry_lk.data;

    // Lane 0 holds entry bits 7:0, lane 3 bits 31:24.
    assign entry_byte = entry_word[stage_lane_q*8 +: 8];

    // Byte-format locations carry data in the low byte only.
    assign entry_answer = FORMAT_32 ? entry_word : {24'h00_0000, entry_byte};

    // The reserved area from 0xF00 to 0xFCB is answered with zero here, so
    // no store can leak into it whatever the entry count.
    assign read_answer = (stage_region_q == DRT_RG_ENTRY) ? entry_answer :
                         (stage_region_q == DRT_RG_IDENT) ? ident_lk.data :
                         WORD_ZERO;

    // A write is answered like a read but returns zero and changes nothing;
    // the written data has no path into any store.
    assign rdata_d = stage_read_q ? read_answer : WORD_ZERO;
    assign ready_d = stage_read_q || stage_write_q;

    // Output registers; the answer strobe lasts one cycle per request.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= RDATA_RESET;
            ready_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            ready_q <= ready_d;
        end
    end

    assign bus_rdata = rdata_q;
    assign bus_ready = ready_q;

    // The write data port exists only to match the bus; it is never read
    // into any state, which is what keeps the table read-only.
    logic unused_wdata; // Reduction sink for the discarded write data.
    assign unused_wdata = ^bus_wdata;

endmodule

`default_nettype wire

// ---- bench/drt_rom_table_properties.sv ----
// Timing and content properties of the table's read port.
// Assumes it is bound to every table instance and sees only its ports.
`timescale 1ns/1ns
`default_nettype none

module drt_rom_table_properties #(
    parameter bit LEGACY = 1'b0,
    parameter bit FORMAT_32 = 1'b1
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic bus_sel,
    input wire logic bus_write,
    input wire logic [11:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic [31:0] bus_rdata,
    input wire logic bus_ready
);
    // All properties share one clock and the reset as their disable.
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    // A read request, named to keep the properties short.
    wire rd = bus_sel && !bus_write;

    property p_lat; bus_sel |-> ##2 bus_ready; endproperty
    a_lat: assert property (p_lat) else $error("no answer two cycles after request");
    property p_only; bus_ready |-> $past(bus_sel, 2); endproperty
    a_only: assert property (p_only) else $error("answer without a request");
    property p_idle; !bus_ready |-> bus_rdata == 32'h0000_0000; endproperty
    a_idle: assert property (p_idle) else $error("read data not zero while idle");
    property p_wr; bus_sel && bus_write |-> ##2 bus_rdata == 32'h0000_0000; endproperty
    a_wr: assert property (p_wr) else $error("write answered with data");
    property p_res; rd && bus_addr >= 12'hF00 && bus_addr <= 12'hFCB |-> ##2 bus_rdata == 0;
    endproperty
    a_res: assert property (p_res) else $error("reserved area not zero");
    property p_top;
        rd && (bus_addr >= 12'hFE0 || (!LEGACY && bus_addr >= 12'hFD0))
            |-> ##2 bus_rdata[31:8] == 24'h00_0000;
    endproperty
    a_top: assert property (p_top) else $error("identification upper bits set");
    property p_spare;
        !LEGACY && rd && bus_addr[11:4] == 8'hFD && bus_addr[3:2] != 2'h0
            |-> ##2 bus_rdata == 32'h0000_0000;
    endproperty
    a_spare: assert property (p_spare) else $error("spare ident word not zero");
    property p_flag; rd && bus_addr[11:2] == 10'h3FA |-> ##2 bus_rdata[3] == !LEGACY; endproperty
    a_flag: assert property (p_flag) else $error("identity flag wrong");
    property p_byte;
        !FORMAT_32 && rd && bus_addr < 12'hF00 |-> ##2 bus_rdata[31:8] == 24'h00_0000;
    endproperty
    a_byte: assert property (p_byte) else $error("byte entry upper bits set");
    property p_rep;
        rd ##1 (rd && $stable(bus_addr)) |-> ##2 bus_rdata == $past(bus_rdata);
    endproperty
    a_rep: assert property (p_rep) else $error("repeated read differs");
endmodule

bind drt_rom_table drt_rom_table_properties #(.LEGACY(LEGACY), .FORMAT_32(FORMAT_32))
    drt_rom_table_properties_i (.clock(clock), .rst(rst), .bus_sel(bus_sel),
    .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_ready(bus_ready));

`default_nettype wire

// ---- bench/drt_bus_model.sv ----
// Behavioural memory access port that reads the table by address.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none

module drt_bus_model (
    input wire logic clock,
    output logic bus_sel,
    output logic bus_write,
    output logic [11:0] bus_addr,
    output logic [31:0] bus_wdata,
    input wire logic [31:0] bus_rdata,
    input wire logic bus_ready
);
    // Answers in arrival order; the bus is pipelined so no tagging is needed.
    logic [31:0] resp_q [$];

    initial begin
        bus_sel = 1'b0;
        bus_write = 1'b0;
        bus_addr = 12'h000;
        bus_wdata = 32'h0000_0000;
    end

    // Whole 32-bit word is kept so the bench can see the upper bits too.
    always @(posedge clock) begin
        if (bus_ready === 1'b1) begin
            resp_q.push_back(bus_rdata);
        end
    end

    // One request per call; calls may follow each other back to back.
    task issue(input logic w, input logic [11:0] a, input logic [31:0] d);
        bus_sel <= 1'b1;
        bus_write <= w;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clock);
    endtask

    // Released lines flip so stale values cannot pass for good ones.
    task idle();
        bus_sel <= 1'b0;
        bus_write <= 1'b0;
        bus_addr <= ~bus_addr;
        bus_wdata <= ~bus_wdata;
        @(posedge clock);
    endtask

    // Waits a bounded time for the oldest answer.
    task take(output logic [31:0] d, output bit ok);
        int n;
        n = 0;
        while (resp_q.size() == 0 && n < 8) begin
            @(posedge clock);
            n++;
        end
        ok = resp_q.size() > 0;
        d = ok ? resp_q.pop_front() : 32'hxxxx_xxxx;
    endtask
endmodule

`default_nettype wire

// ---- bench/test_debug_rom_table_id_space.sv ----
// Self-checking bench: a 32-bit table and a legacy 8-bit table side by side.
// Assumes the bound property checker and the bus model are compiled first.
`timescale 1ns/1ns
`default_nettype none

module test_debug_rom_table_id_space;
    typedef struct {bit b; logic [11:0] a; logic [31:0] e;} drt_row_s;
    logic clock;
    logic rst;
    logic sel_a, wr_a, ready_a, sel_b, wr_b, ready_b;
    logic [11:0] addr_a, addr_b;
    logic [31:0] wdata_a, rdata_a, wdata_b, rdata_b, r;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;
    // Address, expected word; b selects the legacy byte-wide table.
    drt_row_s rows [0:23] = '{
        '{0, 12'h000, 32'hFFF0_F003}, '{0, 12'h004, 32'h0000_2003}, '{0, 12'h008, 0},
        '{0, 12'hEFC, 0}, '{0, 12'hF00, 0}, '{0, 12'hFC8, 0}, '{0, 12'hFCC, 32'h0000_0001},
        '{0, 12'hFD0, 32'h0000_0025}, '{0, 12'hFD4, 0}, '{0, 12'hFDC, 0},
        '{0, 12'hFE0, 32'h0000_00C3}, '{0, 12'hFE4, 32'h0000_00A9}, '{0, 12'hFE8, 32'h0000_003A},
        '{0, 12'hFEC, 32'h0000_0016}, '{0, 12'hFF0, 32'h0000_000D}, '{0, 12'hFFC, 32'h0000_00B1},
        '{1, 12'h000, 32'h0000_0001}, '{1, 12'h004, 32'h0000_0050}, '{1, 12'h008, 32'h0000_0003},
        '{1, 12'h010, 0}, '{1, 12'hFD0, 32'h1111_1111}, '{1, 12'hFDC, 32'h4444_4444},
        '{1, 12'hFE8, 32'h0000_0003}, '{1, 12'hFEC, 32'h0000_008E}};

    // Build options of both tables, kept in one place so the rows above can be read
    // against them; designer and part values are arbitrary neutral codes.
    localparam logic [31:0] A_MEM_TYPE = 32'h0000_0001;
    localparam logic [31:0] A_COMP_ID = 32'hB105_F00D;
    localparam logic [11:0] A_PART = 12'h9C3;
    localparam logic [6:0] A_DESIGNER = 7'h2A;
    localparam logic [3:0] A_COUNT = 4'h2;
    localparam logic [3:0] A_CONT = 4'h5;
    localparam logic [3:0] A_REV = 4'h3;
    localparam logic [3:0] A_REV_AND = 4'h1;
    localparam logic [3:0] A_CUST = 4'h6;
    localparam bit B_FORMAT_32 = 1'b0;
    localparam bit B_LEGACY = 1'b1;
    localparam int B_COUNT = 1;
    localparam logic [31:0] B_ENTRY = 32'h0003_5001;
    localparam logic [6:0] B_DESIGNER = 7'h35;
    localparam logic [7:0] B_BUILD = 8'h8E;
    localparam logic [127:0] B_LEGACY_WORDS = 128'h4444_4444_3333_3333_2222_2222_1111_1111;

    drt_rom_table #(.MEMORY_TYPE(A_MEM_TYPE), .BLOCK_COUNT_LOG2(A_COUNT), .CONTINUATION(A_CONT),
        .DESIGNER_CODE(A_DESIGNER), .PART_NUMBER(A_PART), .REVISION(A_REV), .REV_AND(A_REV_AND),
        .CUSTOMER_MOD(A_CUST), .COMPONENT_ID(A_COMP_ID)) drt_rom_table_i (.clock(clock),
        .rst(rst), .bus_sel(sel_a), .bus_write(wr_a), .bus_addr(addr_a), .bus_wdata(wdata_a),
        .bus_rdata(rdata_a), .bus_ready(ready_a));
    drt_rom_table #(.FORMAT_32(B_FORMAT_32), .NUM_ENTRIES(B_COUNT), .ENTRIES(B_ENTRY),
        .LEGACY(B_LEGACY), .DESIGNER_CODE(B_DESIGNER), .BUILD_CONFIG(B_BUILD),
        .LEGACY_WORDS(B_LEGACY_WORDS)) drt_rom_table_b_i (
        .clock(clock), .rst(rst), .bus_sel(sel_b), .bus_write(wr_b), .bus_addr(addr_b),
        .bus_wdata(wdata_b), .bus_rdata(rdata_b), .bus_ready(ready_b));
    drt_bus_model drt_bus_model_i (.clock(clock), .bus_sel(sel_a), .bus_write(wr_a),
        .bus_addr(addr_a), .bus_wdata(wdata_a), .bus_rdata(rdata_a), .bus_ready(ready_a));
    drt_bus_model drt_bus_model_b_i (.clock(clock), .bus_sel(sel_b), .bus_write(wr_b),
        .bus_addr(addr_b), .bus_wdata(wdata_b), .bus_rdata(rdata_b), .bus_ready(ready_b));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    // One complete access on either table, answer returned in r_out.
    task xfer(input bit b, input logic w, input logic [11:0] a, output logic [31:0] r_out);
        bit ok;
        if (b) begin
            drt_bus_model_b_i.issue(w, a, 32'hA5A5_5A5A);
            drt_bus_model_b_i.idle();
            drt_bus_model_b_i.take(r_out, ok);
        end else begin
            drt_bus_model_i.issue(w, a, 32'hA5A5_5A5A);
            drt_bus_model_i.idle();
            drt_bus_model_i.take(r_out, ok);
        end
        if (!ok) begin
            bad_count++;
            $display("unexpected at %0t: no answer", $time);
        end
    endtask

    task final_report();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // A hang is cut short well past the 150 or so cycles the run needs.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            final_report();
        end
    end

    initial begin
        bit ok;
        rst = 1'b1;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check({31'h0, ready_a}, 32'h0);
        foreach (rows[i]) begin
            xfer(rows[i].b, 1'b0, rows[i].a, r);
            check(r, rows[i].e);
        end
        $display("table rows done");
        // A write is answered with zero and leaves the entry untouched.
        xfer(1'b0, 1'b1, 12'h000, r);
        check(r, 32'h0);
        xfer(1'b1, 1'b1, 12'h004, r);
        check(r, 32'h0);
        xfer(1'b1, 1'b0, 12'h004, r);
        check(r, 32'h0000_0050);
        xfer(1'b0, 1'b0, 12'h000, r);
        check(r, 32'hFFF0_F003);
        $display("write test done");
        // Back-to-back reads, the same place twice, answer in order.
        drt_bus_model_i.issue(1'b0, 12'hFD0, 32'h0);
        drt_bus_model_i.issue(1'b0, 12'hFD0, 32'h0);
        drt_bus_model_i.issue(1'b0, 12'hFEC, 32'h0);
        drt_bus_model_i.idle();
        drt_bus_model_i.take(r, ok);
        check(r, 32'h0000_0025);
        drt_bus_model_i.take(r, ok);
        check(r, 32'h0000_0025);
        drt_bus_model_i.take(r, ok);
        check(r, 32'h0000_0016);
        $display("back to back test done");
        // A reset in mid-run drops the read in flight; nothing is answered for it.
        drt_bus_model_i.issue(1'b0, 12'hFD0, 32'h0);
        rst <= 1'b1;
        drt_bus_model_i.idle();
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check({31'h0, ready_a}, 32'h0);
        check(rdata_a, 32'h0);
        drt_bus_model_i.take(r, ok);
        check({31'h0, ok}, 32'h0);
        xfer(1'b0, 1'b0, 12'hFD0, r);
        check(r, 32'h0000_0025);
        $display("reset test done");
        final_report();
    end
endmodule

`default_nettype wire
